// >>> hdl/ccr_defs.svh
// Constants for the core clock ratio and stop-clock block.
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH
`define CCR_CODE_1_3      2'h1
`define CCR_CODE_2_5      2'h0
`define CCR_CODE_1_2      2'h2
`define CCR_CODE_2_3      2'h3
`define CCR_RATIO_NUM_1_3 3'h1
`define CCR_RATIO_DEN_1_3 3'h3
`define CCR_RATIO_NUM_2_5 3'h2
`define CCR_RATIO_DEN_2_5 3'h5
`define CCR_RATIO_NUM_1_2 3'h1
`define CCR_RATIO_DEN_1_2 3'h2
`define CCR_RATIO_NUM_2_3 3'h2
`define CCR_RATIO_DEN_2_3 3'h3
`define CCR_RST_RATIO     2'h2
`define CCR_SYNC_STAGES   2
`endif

// >>> hdl/ccr_pkg.sv
// Types for the core clock ratio and stop-clock block.
`default_nettype none
package ccr_pkg;
  typedef struct packed {
    logic [2:0] num;
    logic [2:0] den;
    logic       reserved;
  } ccr_ratio_t;
  typedef enum logic [3:0] {
    CCR_RUN   = 4'h1,
    CCR_DRAIN = 4'h2,
    CCR_GRANT = 4'h4,
    CCR_STOP  = 4'h8
  } ccr_state_t;
endpackage
`default_nettype wire

// >>> hdl/ccr_sync.sv
// Two-stage level synchroniser.
`default_nettype none
module ccr_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d_in,
  output var  logic q_out
);
  logic meta_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= RESET_VAL;
      q_out    <= RESET_VAL;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/ccr_top.sv
// Bus-to-core ratio selection and stop-clock handshake.
// Functional notes
// - Decode straps: 01=1/3,00=2/5,10=1/2,11=2/3.
// - Older variant: floating straps give 2/3.
// - Newer variant: floating straps give 1/2.
// - 100 MHz parts accept 1/2 or 2/3.
// - Stop request halts internal core clock.
// - Halt at boundary unless interrupt pending.
// - Issue stop-grant acknowledge after halting.
// - Snoops and interprocessor requests still served.
`include "ccr_defs.svh"
`default_nettype none
module ccr_top #(
  parameter logic NEWER_VARIANT = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ratio_strap_hi,
  input  wire logic              ratio_strap_lo,
  input  wire logic              strap_hi_floating,
  input  wire logic              strap_lo_floating,
  input  wire logic              halt_core_clock_req_n,
  input  wire logic              insn_boundary,
  input  wire logic              intr_pending,
  input  wire logic              grant_cycle_done,
  input  wire logic              snoop_req,
  input  wire logic              ipi_req,
  output var  ccr_pkg::ccr_ratio_t ratio,
  output var  logic              core_clk_en,
  output var  logic              exec_halt,
  output var  logic              stop_grant_cycle,
  output var  logic              service_ack
);
  logic                req_sync_n;
  logic                captured_reg;
  ccr_pkg::ccr_state_t state_reg;
  ccr_pkg::ccr_state_t state_next;

  // Floating straps resolve to the variant default; the newer variant still decodes 2/3 but sets its reserved bit.
  function automatic ccr_pkg::ccr_ratio_t decode_ratio(input logic [1:0] code, input logic newer);
    ccr_pkg::ccr_ratio_t r;
    r = '{num: `CCR_RATIO_NUM_1_2, den: `CCR_RATIO_DEN_1_2, reserved: 1'b0};
    unique case (code)
      `CCR_CODE_1_3: r = '{num: `CCR_RATIO_NUM_1_3, den: `CCR_RATIO_DEN_1_3, reserved: 1'b0};
      `CCR_CODE_2_5: r = '{num: `CCR_RATIO_NUM_2_5, den: `CCR_RATIO_DEN_2_5, reserved: 1'b0};
      `CCR_CODE_1_2: r = '{num: `CCR_RATIO_NUM_1_2, den: `CCR_RATIO_DEN_1_2, reserved: 1'b0};
      `CCR_CODE_2_3: r = '{num: `CCR_RATIO_NUM_2_3, den: `CCR_RATIO_DEN_2_3, reserved: newer};
    endcase
    return r;
  endfunction

  function automatic logic [1:0] strap_code(input logic hi, input logic lo, input logic fhi,
                                            input logic flo, input logic newer);
    logic [1:0] c;
    c = {hi, lo};
    if (fhi && flo) begin
      c = newer ? `CCR_CODE_1_2 : `CCR_CODE_2_3;
    end
    return c;
  endfunction

  ccr_sync #(
    .RESET_VAL (1'b1)
  ) u_req_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d_in  (halt_core_clock_req_n),
    .q_out (req_sync_n)
  );

  // Straps are caught on the first edge after release; reset itself loads only the fixed 1/2 ratio.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      captured_reg <= 1'b0;
      ratio        <= '{num: 3'h1, den: 3'h2, reserved: 1'b0};
    end else if (!captured_reg) begin
      captured_reg <= 1'b1;
      ratio        <= decode_ratio(strap_code(ratio_strap_hi, ratio_strap_lo, strap_hi_floating,
                                              strap_lo_floating, NEWER_VARIANT), NEWER_VARIANT);
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ccr_pkg::CCR_RUN: begin
        if (!req_sync_n) begin
          state_next = ccr_pkg::CCR_DRAIN;
        end
      end
      ccr_pkg::CCR_DRAIN: begin
        if (req_sync_n) begin
          state_next = ccr_pkg::CCR_RUN;
        end else if (insn_boundary && !intr_pending) begin
          state_next = ccr_pkg::CCR_GRANT;
        end
      end
      ccr_pkg::CCR_GRANT: begin
        if (grant_cycle_done) begin
          state_next = ccr_pkg::CCR_STOP;
        end
      end
      ccr_pkg::CCR_STOP: begin
        if (req_sync_n) begin
          state_next = ccr_pkg::CCR_RUN;
        end
      end
      default: state_next = ccr_pkg::CCR_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= ccr_pkg::CCR_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs are registered from the next state so they line up with the state register.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      core_clk_en      <= 1'b1;
      exec_halt        <= 1'b0;
      stop_grant_cycle <= 1'b0;
    end else begin
      core_clk_en      <= (state_next != ccr_pkg::CCR_STOP);
      exec_halt        <= (state_next == ccr_pkg::CCR_GRANT) || (state_next == ccr_pkg::CCR_STOP);
      stop_grant_cycle <= (state_next == ccr_pkg::CCR_GRANT);
    end
  end

  // Snoop logic runs on the bus clock, so it keeps answering while the core clock is stopped.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      service_ack <= 1'b0;
    end else begin
      service_ack <= snoop_req || ipi_req;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/ccr_checker.sv
// Port assertions for the stop-clock handshake.
`default_nettype none
module ccr_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic halt_core_clock_req_n,
  input wire logic insn_boundary,
  input wire logic intr_pending,
  input wire logic grant_cycle_done,
  input wire logic snoop_req,
  input wire logic ipi_req,
  input wire logic core_clk_en,
  input wire logic exec_halt,
  input wire logic stop_grant_cycle,
  input wire logic service_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_req_fell; $fell(halt_core_clock_req_n) && !exec_halt; endsequence
  sequence s_woken; !core_clk_en ##[1:3] core_clk_en; endsequence
  a_ack_late: assert property (1'b1 |=> service_ack == $past(snoop_req | ipi_req)) else $error("ack");
  a_grant_at_bnd: assert property ($rose(stop_grant_cycle) |-> $past(insn_boundary && !intr_pending)) else $error("bnd");
  a_grant_holds: assert property (stop_grant_cycle && !grant_cycle_done |=> stop_grant_cycle) else $error("hold");
  a_clock_stops: assert property (stop_grant_cycle && grant_cycle_done |=> !stop_grant_cycle && !core_clk_en) else $error("stop");
  a_halt_match: assert property (exec_halt == (stop_grant_cycle || !core_clk_en)) else $error("halt");
  a_sync_lag: assert property (s_req_fell |=> !stop_grant_cycle [*3]) else $error("sync");
  a_wake_lag: assert property ($rose(halt_core_clock_req_n) && !core_clk_en |=> s_woken) else $error("wake");
  a_stays_off: assert property (!core_clk_en && !halt_core_clock_req_n |=> !core_clk_en) else $error("off");
endmodule
bind ccr_top ccr_checker i_chk (.*);
`default_nettype wire

// >>> testbench/ccr_sys_model.sv
// System-side model that ends the stop-grant bus cycle after a set delay.
`default_nettype none
module ccr_sys_model (
  input  wire logic       clk,
  input  wire logic       stop_grant_cycle,
  input  wire logic [3:0] delay,
  output var  logic       grant_cycle_done = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_reg = 4'h0;
  always @(posedge clk) begin
    cnt_reg <= stop_grant_cycle && !grant_cycle_done ? cnt_reg + 4'h1 : 4'h0;
    grant_cycle_done <= stop_grant_cycle && !grant_cycle_done && cnt_reg == delay;
  end
endmodule
`default_nettype wire

// >>> testbench/ccr_top_tb.sv
// Testbench for the ratio and stop-clock block.
`default_nettype none
module ccr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] strap = 4'h0;
  logic [4:0] ctl = 5'h10;
  logic [3:0] dly = 4'h0;
  int err_count = 0;
  int check_count = 0;
  wire logic ratio_strap_hi, ratio_strap_lo, strap_hi_floating, strap_lo_floating, halt_core_clock_req_n;
  wire logic insn_boundary, intr_pending, snoop_req, ipi_req, grant_cycle_done;
  logic core_clk_en, exec_halt, stop_grant_cycle, service_ack;
  ccr_pkg::ccr_ratio_t ratio, ratio_new;
  assign {ratio_strap_hi, ratio_strap_lo, strap_hi_floating, strap_lo_floating} = strap;
  assign {halt_core_clock_req_n, insn_boundary, intr_pending, snoop_req, ipi_req} = ctl;
  ccr_top i_dut (.*);
  ccr_top #(.NEWER_VARIANT(1'b1)) i_new (.*, .ratio(ratio_new), .core_clk_en(), .exec_halt(), .stop_grant_cycle(),
    .service_ack());
  ccr_sys_model i_sys (.clk, .stop_grant_cycle, .delay(dly), .grant_cycle_done);
  always #10 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic ok);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH at %0t: wrong output", $time);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic ccr_pkg::ccr_ratio_t exp_ratio(input logic [3:0] s, input logic nw);
    if (s[1:0] == 2'h3) return nw ? 7'h14 : 7'h26;
    case (s[3:2])
      2'h1: return 7'h16;
      2'h0: return 7'h2A;
      2'h2: return 7'h14;
      default: return {6'h13, nw};
    endcase
  endfunction
  task automatic t_ratio(input logic [3:0] s);
    strap <= s;
    rst_b <= 1'b0;
    step(2);
    rst_b <= 1'b1;
    step(1);
    strap <= ~s;
    step(2);
    #1 chk(ratio === exp_ratio(s, 1'b0));
    chk(ratio_new === exp_ratio(s, 1'b1));
    step(1);
  endtask
  task automatic t_stop(input logic [3:0] d);
    dly <= d;
    ctl <= 5'h0C;
    step(6);
    #1 chk(exec_halt === 1'b0);
    step(1);
    ctl <= 5'h0B;
    #1;
    for (int k = 0; k < 8 && stop_grant_cycle !== 1'b1; k++) begin
      step(1);
      #1;
    end
    chk(stop_grant_cycle === 1'b1 && exec_halt === 1'b1);
    for (int k = 0; k < 20 && core_clk_en !== 1'b0; k++) begin
      step(1);
      #1;
    end
    chk(exec_halt === 1'b1 && service_ack === 1'b1);
    step(1);
    ctl <= 5'h10;
    #1;
    for (int k = 0; k < 8 && core_clk_en !== 1'b1; k++) begin
      step(1);
      #1;
    end
    chk(exec_halt === 1'b0);
    step(1);
  endtask
  initial begin
    step(10);
    rst_b <= 1'b1;
    step(2);
    t_stop(4'h0);
    t_stop(4'h3);
    for (int i = 0; i < 5; i++) t_ratio(i < 4 ? 4'(i * 4) : 4'h3);
    conclude();
  end
  initial begin
    #100us;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
